/* design/ptlpc_consts.svh */
// Constants for the pulse train limit/position channel
`ifndef PTLPC_CONSTS_SVH
`define PTLPC_CONSTS_SVH

`define PTLPC_CLK_HZ         32'h0EE6_B280
`define PTLPC_FREQ_MIN       16'h0014
`define PTLPC_FREQ_MAX       16'h4E20
`define PTLPC_DUTY_MAX       8'h63
`define PTLPC_DUTY_DFLT      8'h32
`define PTLPC_DUTY_SCALE     32'h0000_0064
`define PTLPC_POS_MAX        32'h7FFF_4020
`define PTLPC_STEP_FOREVER   32'hFFFF_FFFF

`define PTLPC_ERR_NONE       16'h0000
`define PTLPC_ERR_LIMIT_CFG  16'h0068
`define PTLPC_ERR_LIMIT_EDGE 16'h0069
`define PTLPC_ERR_FUNC_NUM   16'h006B
`define PTLPC_ERR_RANGE      16'h006F

`define PTLPC_CODE_HI        7:4
`define PTLPC_CODE_LO        3:0
`define PTLPC_CODE_SEL       1:0
`define PTLPC_CODE_SEL_PAD   3:2
`define PTLPC_EDGE_RISE      4'h0
`define PTLPC_EDGE_FALL      4'h1
`define PTLPC_EDGE_BOTH      4'h2
`define PTLPC_CMP_LESS       4'h0
`define PTLPC_CMP_GREATER    4'h1
`define PTLPC_SEL_MAX        4'h3

`define PTLPC_TRIG_LIMIT     0
`define PTLPC_TRIG_POSITION  1
`define PTLPC_TRIG_VELOCITY  2
`define PTLPC_TRIG_READ      3

`endif

/* design/ptlpc_pkg.sv */
// Types for the pulse train limit/position channel
package ptlpc_pkg;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_CHECK,
      ST_SCALE
   } ptlpc_state_t;

   typedef enum logic [2:0] {
      MODE_NONE,
      MODE_LIMIT,
      MODE_POSITION,
      MODE_VELOCITY,
      MODE_READ
   } ptlpc_mode_t;

endpackage : ptlpc_pkg

/* design/ptlpc_pulse_gen.sv */
// Integer divider pulse train generator
`timescale 1ns/10ps
module ptlpc_pulse_gen #(
   parameter int unsigned CNT_W = 24
) (
   input  wire logic             ref_clk,
   input  wire logic             resetn,
   input  wire logic             run,
   input  wire logic [CNT_W-1:0] periodCyc,
   input  wire logic [CNT_W-1:0] highCyc,
   output logic                  pulseOut,
   output logic                  periodDone
);

   if (CNT_W < 2) begin : g_bad_width
      $error("ptlpc_pulse_gen: CNT_W too small");
   end

   logic [CNT_W-1:0] cntFf;
   logic [CNT_W-1:0] nxt_cnt;
   logic             pulseFf;
   logic             nxt_pulse;
   logic             doneFf;
   logic             nxt_done;
   logic [CNT_W-1:0] highSeenFf;
   logic [CNT_W-1:0] nxt_highSeen;

   ////////////////////////////////////////////////////////////////////////
   // divided period, low when stopped
   always_comb begin
      nxt_cnt      = cntFf;
      nxt_pulse    = 1'b0;
      nxt_done     = 1'b0;
      nxt_highSeen = highSeenFf;
      if (!run) begin
         nxt_cnt      = '0;
         nxt_highSeen = '0;
      end else begin
         nxt_pulse = (cntFf < highCyc);
         if (cntFf >= periodCyc - {{(CNT_W-1){1'b0}}, 1'b1}) begin
            nxt_cnt  = '0;
            nxt_done = 1'b1;
         end else begin
            nxt_cnt = cntFf + {{(CNT_W-1){1'b0}}, 1'b1};
         end
         // Counts high cycles of the period just ending, for checking only
         if (doneFf) begin
            nxt_highSeen = {{(CNT_W-1){1'b0}}, pulseFf};
         end else if (pulseFf) begin
            nxt_highSeen = highSeenFf + {{(CNT_W-1){1'b0}}, 1'b1};
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         cntFf      <= '0;
         pulseFf    <= 1'b0;
         doneFf     <= 1'b0;
         highSeenFf <= '0;
      end else begin
         cntFf      <= nxt_cnt;
         pulseFf    <= nxt_pulse;
         doneFf     <= nxt_done;
         highSeenFf <= nxt_highSeen;
      end
   end

   assign pulseOut   = pulseFf;
   assign periodDone = doneFf;

   ////////////////////////////////////////////////////////////////////////
   chk_high_share: assert property (
      @(posedge ref_clk) disable iff (!resetn)
      (run && $past(run) && $past(run, 2) && $stable(highCyc) && $stable(periodCyc)
         && cntFf == '0 && doneFf && highSeenFf != '0)
      |-> (highSeenFf == highCyc || highSeenFf == periodCyc))
      else $error("high time differs from commanded share");

   chk_off_low: assert property (
      @(posedge ref_clk) disable iff (!resetn)
      !run |=> !pulseOut)
      else $error("pulse output high while stopped");

endmodule : ptlpc_pulse_gen

/* design/ptlpc_channel.sv */
// Command handler and pulse output for one output channel
`timescale 1ns/10ps
`include "ptlpc_consts.svh"

module ptlpc_channel #(
   parameter logic [7:0]  MODULE_ID  = 8'h01,
   parameter logic [1:0]  CHAN_INDEX = 2'h0,
   parameter int unsigned CNT_W      = 24
) (
   input  wire logic                ref_clk,
   input  wire logic                resetn,
   input  wire logic                runToLimitCmd,
   input  wire logic                runToPositionCmd,
   input  wire logic                velocityCmd,
   input  wire logic                readErrorCodeCmd,
   input  wire logic [7:0]          moduleIdIn,
   input  wire logic [1:0]          chanSelIn,
   input  wire logic [15:0]         freqHzIn,
   input  wire logic [7:0]          dutyPctIn,
   input  wire logic [7:0]          limitCodeIn,
   input  wire logic [7:0]          compareCodeIn,
   input  wire logic [31:0]         positionIn,
   input  wire logic [31:0]         stepCountIn,
   input  wire logic [3:0]          limitCfgIn,
   input  wire logic                chan1InputC,
   input  wire logic                chan1InputD,
   input  wire logic                chan2InputC,
   input  wire logic                chan2InputD,
   input  wire logic [31:0]         compareFunctionOneCh1,
   input  wire logic [31:0]         compareFunctionTwoCh1,
   input  wire logic [31:0]         compareFunctionOneCh2,
   input  wire logic [31:0]         compareFunctionTwoCh2,
   input  wire logic                chanEnable,
   input  wire logic                chanDirection,
   output logic                     cmdSuccess,
   output logic                     cmdError,
   output logic [15:0]              errCodeOut,
   output logic                     pulseOut,
   output logic                     dirOut,
   output logic                     channelArmed,
   output ptlpc_pkg::ptlpc_mode_t   activeMode
);
   import ptlpc_pkg::*;

   if (CNT_W < 24 || CNT_W > 31) begin : g_bad_width
      $error("ptlpc_channel: CNT_W must hold the slowest period");
   end

   ////////////////////////////////////////////////////////////////////////
   // State
   ptlpc_state_t     stateFf,    nxt_state;
   ptlpc_mode_t      modeFf,     nxt_mode;
   logic [15:0]      freqFf,     nxt_freq;
   logic [7:0]       dutyFf,     nxt_duty;
   logic [7:0]       limitFf,    nxt_limit;
   logic [7:0]       cmpFf,      nxt_cmp;
   logic [31:0]      posFf,      nxt_pos;
   logic [31:0]      stepFf,     nxt_step;
   logic [CNT_W-1:0] periodFf,   nxt_period;
   logic [CNT_W-1:0] highFf,     nxt_high;
   logic             successFf,  nxt_success;
   logic             errorFf,    nxt_error;
   logic [15:0]      lastErrFf,  nxt_lastErr;
   logic [15:0]      errReadFf,  nxt_errRead;
   logic             armedFf,    nxt_armed;
   logic [31:0]      pulseCntFf, nxt_pulseCnt;
   logic [3:0]       trigPrevFf;
   logic [3:0]       limPrevFf;
   logic             dirFf;

   logic [3:0]       trigVec;
   logic [3:0]       trigRise;
   logic [3:0]       limVec;
   logic [3:0]       limRise;
   logic [3:0]       limFall;
   logic             addrHit;
   logic             idHit;
   logic             limitHit;
   logic             posHit;
   logic             stepHit;
   logic             stopNow;
   logic [31:0]      cmpCount;
   logic [15:0]      divisor;
   logic [31:0]      periodWide;
   logic [31:0]      scaledWide;
   logic [31:0]      highWide;
   logic [15:0]      checkErr;
   logic             periodDone;
   logic             genRun;

   ////////////////////////////////////////////////////////////////////////
   // Edge detection and selection
   assign trigVec = {readErrorCodeCmd, velocityCmd, runToPositionCmd, runToLimitCmd};
   // only a fresh rising edge counts
   assign trigRise = trigVec & ~trigPrevFf;
   // module number must match, and channel too for load commands
   assign idHit   = (moduleIdIn == MODULE_ID);
   assign addrHit = idHit && (chanSelIn == CHAN_INDEX);

   assign limVec  = {chan2InputD, chan2InputC, chan1InputD, chan1InputC};
   assign limRise = limVec & ~limPrevFf;
   assign limFall = ~limVec & limPrevFf;

   // input digit picks the line, edge digit the sense
   assign limitHit =
      ((limitFf[`PTLPC_CODE_HI] == `PTLPC_EDGE_RISE ||
        limitFf[`PTLPC_CODE_HI] == `PTLPC_EDGE_BOTH) && limRise[limitFf[`PTLPC_CODE_SEL]]) ||
      ((limitFf[`PTLPC_CODE_HI] == `PTLPC_EDGE_FALL ||
        limitFf[`PTLPC_CODE_HI] == `PTLPC_EDGE_BOTH) && limFall[limitFf[`PTLPC_CODE_SEL]]);

   // function digit selects the encoder count
   always_comb begin
      cmpCount = compareFunctionOneCh1;
      case (cmpFf[`PTLPC_CODE_SEL])
         2'h0:    cmpCount = compareFunctionOneCh1;
         2'h1:    cmpCount = compareFunctionTwoCh1;
         2'h2:    cmpCount = compareFunctionOneCh2;
         default: cmpCount = compareFunctionTwoCh2;
      endcase
   end

   // relation digit picks greater-than or less-than
   assign posHit = (cmpFf[`PTLPC_CODE_HI] == `PTLPC_CMP_GREATER) ? (cmpCount > posFf)
                                                                  : (cmpCount < posFf);
   // Counts the period ending now, so no extra pulse starts after the last one
   assign stepHit = (stepFf != `PTLPC_STEP_FOREVER) &&
                    ((pulseCntFf + 32'(periodDone)) >= stepFf);

   always_comb begin
      stopNow = 1'b0;
      case (modeFf)
         // a limit edge ends the train
         MODE_LIMIT:    stopNow = limitHit;
         MODE_POSITION: stopNow = posHit;
         MODE_VELOCITY: stopNow = stepHit;
         default:       stopNow = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Parameter checks and period arithmetic
   // Divisor kept nonzero so the divider never sees zero
   assign divisor    = (freqFf < `PTLPC_FREQ_MIN) ? `PTLPC_FREQ_MIN : freqFf;
   // clock over frequency gives the period in cycles
   assign periodWide = `PTLPC_CLK_HZ / {16'h0000, divisor};
   // Worst product stays below two to the thirty-first
   assign scaledWide = {{(32-CNT_W){1'b0}}, periodFf} * {24'h00_0000, dutyFf};
   assign highWide   = scaledWide / `PTLPC_DUTY_SCALE;

   always_comb begin
      checkErr = `PTLPC_ERR_NONE;
      if (freqFf < `PTLPC_FREQ_MIN || freqFf > `PTLPC_FREQ_MAX ||
          dutyFf > `PTLPC_DUTY_MAX) begin
         checkErr = `PTLPC_ERR_RANGE;
      end else if (modeFf == MODE_LIMIT) begin
         if (limitFf[`PTLPC_CODE_SEL_PAD] != 2'h0 ||
             limitFf[`PTLPC_CODE_HI] > `PTLPC_EDGE_BOTH) begin
            checkErr = `PTLPC_ERR_LIMIT_EDGE;
         // referenced input must be a limit
         end else if (!limitCfgIn[limitFf[`PTLPC_CODE_SEL]]) begin
            // not a limit on this output
            checkErr = `PTLPC_ERR_LIMIT_CFG;
         end
      end else if (modeFf == MODE_POSITION) begin
         if (cmpFf[`PTLPC_CODE_HI] > `PTLPC_CMP_GREATER ||
             cmpFf[`PTLPC_CODE_LO] > `PTLPC_SEL_MAX) begin
            checkErr = `PTLPC_ERR_FUNC_NUM;
         end else if (posFf > `PTLPC_POS_MAX) begin
            checkErr = `PTLPC_ERR_RANGE;
         end
      end else if (modeFf == MODE_VELOCITY) begin
         if (stepFf > `PTLPC_POS_MAX && stepFf != `PTLPC_STEP_FOREVER) begin
            checkErr = `PTLPC_ERR_RANGE;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Command sequencer
   always_comb begin
      nxt_state    = stateFf;
      nxt_mode     = modeFf;
      nxt_freq     = freqFf;
      nxt_duty     = dutyFf;
      nxt_limit    = limitFf;
      nxt_cmp      = cmpFf;
      nxt_pos      = posFf;
      nxt_step     = stepFf;
      nxt_period   = periodFf;
      nxt_high     = highFf;
      nxt_success  = successFf;
      nxt_error    = errorFf;
      nxt_lastErr  = lastErrFf;
      nxt_errRead  = errReadFf;
      nxt_armed    = armedFf;
      nxt_pulseCnt = pulseCntFf;
      if (armedFf && periodDone) begin
         nxt_pulseCnt = pulseCntFf + 32'h0000_0001;
      end
      case (stateFf)
         ST_IDLE: begin
            if (armedFf && stopNow) begin
               nxt_armed = 1'b0;
            end
            // load on the edge, flags clear until completion
            if (addrHit && (trigRise[`PTLPC_TRIG_LIMIT] || trigRise[`PTLPC_TRIG_POSITION] ||
                            trigRise[`PTLPC_TRIG_VELOCITY])) begin
               nxt_state   = ST_CHECK;
               nxt_freq    = freqHzIn;
               nxt_duty    = dutyPctIn;
               nxt_success = 1'b0;
               nxt_error   = 1'b0;
               nxt_armed   = 1'b0;
               if (trigRise[`PTLPC_TRIG_LIMIT]) begin
                  nxt_mode  = MODE_LIMIT;
                  nxt_limit = limitCodeIn;
               end else if (trigRise[`PTLPC_TRIG_POSITION]) begin
                  nxt_mode = MODE_POSITION;
                  nxt_cmp  = compareCodeIn;
                  nxt_pos  = positionIn;
               end else begin
                  nxt_mode = MODE_VELOCITY;
                  nxt_step = stepCountIn;
               end
            end else if (idHit && trigRise[`PTLPC_TRIG_READ]) begin
               // Read leaves a running train alone
               nxt_errRead = lastErrFf;
               nxt_success = 1'b1;
               nxt_error   = 1'b0;
            end
         end
         ST_CHECK: begin
            if (checkErr != `PTLPC_ERR_NONE) begin
               nxt_error   = 1'b1;
               nxt_lastErr = checkErr;
               nxt_state   = ST_IDLE;
            end else begin
               nxt_period = periodWide[CNT_W-1:0];
               // zero duty stands for the default
               if (dutyFf == 8'h00) begin
                  nxt_duty = `PTLPC_DUTY_DFLT;
               end
               nxt_state = ST_SCALE;
            end
         end
         ST_SCALE: begin
            nxt_high     = highWide[CNT_W-1:0];
            nxt_success  = 1'b1;
            nxt_lastErr  = `PTLPC_ERR_NONE;
            nxt_armed    = 1'b1;
            nxt_pulseCnt = 32'h0000_0000;
            nxt_state    = ST_IDLE;
         end
         default: nxt_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         stateFf    <= ST_IDLE;
         modeFf     <= MODE_NONE;
         freqFf     <= 16'h0000;
         dutyFf     <= 8'h00;
         limitFf    <= 8'h00;
         cmpFf      <= 8'h00;
         posFf      <= 32'h0000_0000;
         stepFf     <= 32'h0000_0000;
         periodFf   <= '0;
         highFf     <= '0;
         successFf  <= 1'b0;
         errorFf    <= 1'b0;
         lastErrFf  <= `PTLPC_ERR_NONE;
         errReadFf  <= `PTLPC_ERR_NONE;
         armedFf    <= 1'b0;
         pulseCntFf <= 32'h0000_0000;
         trigPrevFf <= 4'h0;
         limPrevFf  <= 4'h0;
         dirFf      <= 1'b0;
      end else begin
         stateFf    <= nxt_state;
         modeFf     <= nxt_mode;
         freqFf     <= nxt_freq;
         dutyFf     <= nxt_duty;
         limitFf    <= nxt_limit;
         cmpFf      <= nxt_cmp;
         posFf      <= nxt_pos;
         stepFf     <= nxt_step;
         periodFf   <= nxt_period;
         highFf     <= nxt_high;
         successFf  <= nxt_success;
         errorFf    <= nxt_error;
         lastErrFf  <= nxt_lastErr;
         errReadFf  <= nxt_errRead;
         armedFf    <= nxt_armed;
         pulseCntFf <= nxt_pulseCnt;
         trigPrevFf <= trigVec;
         limPrevFf  <= limVec;
         dirFf      <= chanDirection;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pulse output
   // pulses only while host holds enable
   // Stop condition cuts the train at once, before another period can begin
   assign genRun = armedFf && chanEnable && !stopNow;

   ptlpc_pulse_gen #(
      .CNT_W      (CNT_W)
   ) u_pulse_gen (
      .ref_clk    (ref_clk),
      .resetn     (resetn),
      .run        (genRun),
      .periodCyc  (periodFf),
      .highCyc    (highFf),
      .pulseOut   (pulseOut),
      .periodDone (periodDone)
   );

   assign cmdSuccess   = successFf;
   assign cmdError     = errorFf;
   assign errCodeOut   = errReadFf;
   assign dirOut       = dirFf;
   assign channelArmed = armedFf;
   assign activeMode   = modeFf;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   chk_edge_only_load: assert property (
      (stateFf == ST_IDLE && addrHit && runToLimitCmd && $past(runToLimitCmd) &&
       !runToPositionCmd && !velocityCmd) |=> stateFf == ST_IDLE)
      else $error("held trigger loaded a second command");

   chk_flags_exclusive: assert property (
      !(successFf && errorFf))
      else $error("success and error both set");

   chk_done_bound: assert property (
      stateFf == ST_CHECK |-> ##[1:2] (successFf || errorFf))
      else $error("command did not complete in time");

   chk_freq_window: assert property (
      ($rose(successFf) && $past(stateFf) == ST_SCALE) |->
         (freqFf >= `PTLPC_FREQ_MIN && freqFf <= `PTLPC_FREQ_MAX))
      else $error("out of range frequency accepted");

   chk_duty_default: assert property (
      (stateFf == ST_CHECK && dutyFf == 8'h00 && checkErr == `PTLPC_ERR_NONE)
      |=> dutyFf == `PTLPC_DUTY_DFLT ##1 successFf)
      else $error("zero duty not turned into default");

   chk_limit_stop: assert property (
      (stateFf == ST_IDLE && modeFf == MODE_LIMIT && armedFf && limitHit &&
       trigRise == 4'h0) |=> !armedFf ##1 !pulseOut)
      else $error("limit edge did not stop the train");

   chk_position_stop: assert property (
      (stateFf == ST_IDLE && modeFf == MODE_POSITION && armedFf && posHit &&
       trigRise == 4'h0) |=> !armedFf ##1 !pulseOut)
      else $error("position reached but pulses continue");

   chk_code_104: assert property (
      ($rose(errorFf) && modeFf == MODE_LIMIT &&
       limitFf[`PTLPC_CODE_SEL_PAD] == 2'h0 &&
       limitFf[`PTLPC_CODE_HI] <= `PTLPC_EDGE_BOTH &&
       !limitCfgIn[limitFf[`PTLPC_CODE_SEL]]) |-> lastErrFf == `PTLPC_ERR_LIMIT_CFG)
      else $error("unconfigured limit not reported as 104");

   chk_disabled_low: assert property (
      !chanEnable |=> !pulseOut)
      else $error("pulse output high with enable clear");

endmodule : ptlpc_channel

/* sim/ptlpc_host_model.sv */
// Host controller model issuing channel commands
`timescale 1ns/10ps
module ptlpc_host_model (
   input  wire logic        ref_clk,
   output logic [3:0]       trig,
   output logic [7:0]       modId,
   output logic [1:0]       chan,
   output logic [15:0]      freq,
   output logic [7:0]       duty,
   output logic [7:0]       code,
   output logic [31:0]      val
);
   logic [7:0] useId = 8'h01;
   initial begin
      trig = 4'h0;
      {modId, chan, freq, duty, code, val} = '0;
   end
   task automatic issue(input int k, input logic [15:0] f, input logic [7:0] d,
                        input logic [7:0] c, input logic [31:0] v, input int hold);
      @(posedge ref_clk);
      #1;
      {modId, chan, freq, duty, code, val} = {useId, 2'h0, f, d, c, v};
      trig[k] = 1'b1;
      repeat (hold) @(posedge ref_clk);
      #1;
      trig = 4'h0;
   endtask : issue
endmodule : ptlpc_host_model

/* sim/tb_top.sv */
// Self-checking bench for one pulse output channel
`timescale 1ns/10ps
module tb_top;
   import ptlpc_pkg::*;
   logic              ref_clk = 1'b0;
   logic              resetn = 1'b0;
   logic              en = 1'b0;
   logic [3:0]        lim = 4'h0;
   logic [3:0]        cfg = 4'h1;
   logic [31:0]       enc [4] = '{default: 32'h0000_0000};
   logic [3:0]        trig;
   logic [7:0]        modId, duty, code;
   logic [1:0]        chan;
   logic [15:0]       freq, eCode;
   logic [31:0]       val;
   logic              suc, err, pls, dir, armed;
   ptlpc_mode_t       mode;
   int                errCount = 0;
   int                numChecks = 0;

   ptlpc_host_model hostU (.ref_clk(ref_clk), .trig(trig), .modId(modId), .chan(chan),
      .freq(freq), .duty(duty), .code(code), .val(val));
   ptlpc_channel dut_u (.ref_clk(ref_clk), .resetn(resetn), .runToLimitCmd(trig[0]),
      .runToPositionCmd(trig[1]), .velocityCmd(trig[2]), .readErrorCodeCmd(trig[3]),
      .moduleIdIn(modId), .chanSelIn(chan), .freqHzIn(freq), .dutyPctIn(duty),
      .limitCodeIn(code), .compareCodeIn(code), .positionIn(val), .stepCountIn(val),
      .limitCfgIn(cfg), .chan1InputC(lim[0]), .chan1InputD(lim[1]), .chan2InputC(lim[2]),
      .chan2InputD(lim[3]), .compareFunctionOneCh1(enc[0]), .compareFunctionTwoCh1(enc[1]),
      .compareFunctionOneCh2(enc[2]), .compareFunctionTwoCh2(enc[3]), .chanEnable(en),
      .chanDirection(en), .cmdSuccess(suc), .cmdError(err), .errCodeOut(eCode),
      .pulseOut(pls), .dirOut(dir), .channelArmed(armed), .activeMode(mode));

   initial forever #2 ref_clk = ~ref_clk;

   ////////////////////////////////////////////////////////////////////////////////
   task automatic summarize;
      $display("checks %0d mismatches %0d", numChecks, errCount);
      if (errCount == 0 && numChecks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : summarize

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      numChecks++;
      if (got !== exp) begin
         errCount++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : tick

   // Reference outcome of a load command, range test first
   function automatic int expErr(int k, int f, int d, logic [7:0] c, logic [31:0] v);
      if (f < 20 || f > 20000 || d > 99) return 111;
      if (k != 0 && v > 32'h7FFF_4020 && !(k == 2 && v == 32'hFFFF_FFFF)) return 111;
      if (k == 0 && (c[3:2] != 2'h0 || c[7:4] > 4'h2)) return 105;
      if (k == 0 && !cfg[c[1:0]]) return 104;
      if (k == 1 && (c[7:4] > 4'h1 || c[3:0] > 4'h3)) return 107;
      return 0;
   endfunction : expErr

   // Load, await completion, then fetch the error code
   task automatic cmd(input int k, input int f, input int d, input logic [7:0] c,
                      input logic [31:0] v);
      int e;
      int n;
      e = expErr(k, f, d, c, v);
      hostU.issue(k, f[15:0], d[7:0], c, v, 1);
      n = 0;
      while (suc !== 1'b1 && err !== 1'b1 && n < 10) begin
         tick(1);
         n++;
      end
      chk(err, e != 0, "error flag");
      chk(suc, e == 0, "success flag");
      chk(mode, k + 1, "mode");
      hostU.issue(3, 16'h0000, 8'h00, 8'h00, 32'h0000_0000, 1);
      tick(1);
      chk(eCode, e, "error code");
      chk({suc, err}, 2'h2, "read flags");
   endtask : cmd

   task automatic span(input logic l, input int m, output int n);
      n = 0;
      while (pls === l && n < m) begin
         tick(1);
         n++;
      end
   endtask : span

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #380000;
      errCount++;
      $display("CHECK FAILED t=%0t watchdog expired", $time);
      summarize();
   end

   initial begin
      int n, hi, lo, f, d, p;
      logic [31:0] q;
      logic prev;
      void'($urandom(80442));
      tick(3);
      resetn = 1'b1;
      chk({suc, err, armed, pls}, 4'h0, "reset state");
      cmd(0, 19, 0, 8'h00, 0);
      cmd(0, 20001, 0, 8'h00, 0);
      cmd(0, 20, 99, 8'h00, 0);
      cmd(0, 1000, 100, 8'h00, 0);
      cmd(0, 1000, 0, 8'h30, 0);
      cmd(0, 1000, 0, 8'h04, 0);
      cmd(0, 1000, 0, 8'h01, 0);
      cmd(1, 1000, 0, 8'h04, 0);
      cmd(1, 1000, 0, 8'h20, 0);
      cmd(1, 1000, 0, 8'h13, 32'h7FFF_4021);
      cmd(2, 1000, 0, 8'h00, 32'h8000_0000);
      cmd(2, 1000, 0, 8'h00, 32'hFFFF_FFFF);
      // Held trigger must not reload
      fork
         hostU.issue(0, 16'h4E20, 8'h00, 8'h00, 32'h0000_0000, 8);
      join_none
      tick(5);
      repeat (6) begin
         tick(1);
         chk(suc, 1'b1, "held trigger");
      end
      hostU.useId = 8'h02;
      hostU.issue(0, 16'h4E20, 8'h00, 8'h30, 32'h0000_0000, 1);
      tick(5);
      chk({suc, err}, 2'h2, "foreign module");
      hostU.useId = 8'h01;
      for (int i = 0; i < 3; i++) begin
         f = (i < 2 || $urandom_range(1, 0) == 0) ? 20000 : 15625;
         d = (i == 0) ? 0 : (i == 1) ? 50 : $urandom_range(99, 1);
         p = 250000000 / f;
         lim = 4'h0;
         cmd(0, f, d, 8'h00, 0);
         en = 1'b1;
         span(1'b1, p, n);
         span(1'b0, p, n);
         span(1'b1, p, hi);
         span(1'b0, p, lo);
         chk(hi, p * ((d == 0) ? 50 : d) / 100, "high time");
         chk(hi + lo, p, "period");
         chk(dir, 1'b1, "direction");
         en = 1'b0;
         tick(2);
         repeat (20) begin
            tick(1);
            chk(pls, 1'b0, "disabled low");
         end
      end
      cfg = 4'hF;
      for (int i = 0; i < 12; i++) begin
         lim = (i < 4) ? 4'hF : 4'h0;
         cmd(0, 20000, 0, {4'(i / 4), 2'h0, 2'(i % 4)}, 0);
         lim = lim ^ ~(4'h1 << (i % 4));
         tick(3);
         lim = lim ^ ~(4'h1 << (i % 4));
         tick(3);
         chk(armed, 1'b1, "other inputs ignored");
         lim[i % 4] = ~lim[i % 4];
         tick(3);
         chk(armed, i < 8, "first transition");
         lim[i % 4] = ~lim[i % 4];
         tick(3);
         chk({armed, pls}, 2'h0, "limit stop");
      end
      for (int i = 0; i < 8; i++) begin
         q = 32'($urandom_range(100000, 1000));
         enc = '{default: q};
         cmd(1, 20000, 0, {4'(i / 4), 4'(i % 4)}, q);
         enc = '{default: (i < 4) ? q - 1 : q + 1};
         enc[i % 4] = q;
         tick(3);
         chk(armed, 1'b1, "compare select");
         enc[i % 4] = (i < 4) ? q - 1 : q + 1;
         tick(3);
         chk({armed, pls}, 2'h0, "position stop");
      end
      cmd(2, 20000, 0, 8'h00, 32'h0000_0002);
      en = 1'b1;
      n = 0;
      p = 0;
      while (armed === 1'b1 && p < 40000) begin
         prev = pls;
         tick(1);
         n += (pls === 1'b1 && prev === 1'b0);
         p++;
      end
      chk(n, 2, "velocity pulses");
      summarize();
   end
endmodule : tb_top
